// ===== nqd_core.sv
// Top of the queued non-data command decoder: command port, queue state, AHB-Lite slave
`timescale 1ns/100ps
module nqd_core
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Command from the link layer
  input wire logic CMD_VALID_I,
  input wire nqd_pkg::nqd_cmd_t CMD_I,
  output logic CMD_READY_O,
  // Queue bookkeeping from the queued data path
  input wire logic Q_ISSUE_I,
  input wire logic [4:0] Q_ISSUE_TAG_I,
  input wire logic Q_ISSUE_STREAM_I,
  input wire logic Q_ISSUE_WRITE_I,
  input wire logic [1:0] Q_ISSUE_PRIORITY_CLASS_I,
  input wire logic [31:0] Q_DONE_I,
  input wire logic [31:0] LIMIT_EXPIRED_I,
  // Response to the link layer
  output logic RESP_VALID_O,
  output nqd_pkg::nqd_resp_t RESP_O,
  output logic [31:0] ABORT_MASK_O,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] outstand_r;
  logic [31:0] stream_r;
  logic [31:0] write_r;
  logic [31:0] isoch_r;
  logic [31:0] limit_hit_r;
  logic [31:0] aborted_r;
  logic wstrict_r;
  logic rstrict_r;
  logic resp_valid_r;
  nqd_pkg::nqd_resp_t resp_r;
  logic [31:0] abort_mask_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic is_abort;
  logic is_deadline;
  logic [3:0] kind;
  logic [4:0] own_tag;
  logic [4:0] target_tag;
  logic wstrict;
  logic rstrict;
  logic reject;

  nqd_decode nqd_decode_inst
  (
    .cmd_i(CMD_I),
    .queue_en_i(ctrl_r[nqd_pkg::CTRL_QEN_BIT]),
    .max_tag_i(ctrl_r[12:8]),
    .is_abort_o(is_abort),
    .is_deadline_o(is_deadline),
    .kind_o(kind),
    .own_tag_o(own_tag),
    .target_tag_o(target_tag),
    .wstrict_o(wstrict),
    .rstrict_o(rstrict),
    .reject_o(reject)
  );

  function automatic logic [31:0] tag_bit(input logic [4:0] t);
    tag_bit = 32'h00000001 << t;
  endfunction

  // One command at a time; a pending response stalls the next
  assign CMD_READY_O = !resp_valid_r;
  // Other opcodes are dropped with no answer; the link layer is trusted to filter them
  wire cmd_take = CMD_VALID_I && CMD_READY_O && CMD_I.opcode == nqd_pkg::OPCODE;

  // Kinds select a subset of outstanding tags; nonmatching classes untouched
  wire [31:0] sel_all = outstand_r;
  wire [31:0] sel_stream = outstand_r & stream_r;
  wire [31:0] sel_nonstream = outstand_r & ~stream_r;
  wire [31:0] sel_one = outstand_r & tag_bit(target_tag);
  wire [31:0] abort_sel =
    (kind == nqd_pkg::ABORT_ALL) ? sel_all :
    (kind == nqd_pkg::ABORT_STREAM) ? sel_stream :
    (kind == nqd_pkg::ABORT_NONSTREAM) ? sel_nonstream : sel_one;

  // Strict flags only guard isochronous class tags of the matching direction
  wire [31:0] strict_guard = isoch_r & ((wstrict_r ? write_r : 32'h00000000)
    | (rstrict_r ? ~write_r : 32'h00000000));
  // Overruns of unguarded tags are tolerated; guarded ones abort the queue
  wire overrun = |(outstand_r & strict_guard & LIMIT_EXPIRED_I);

  wire cmd_ok = cmd_take && !reject;
  wire [31:0] abort_now = overrun ? outstand_r :
    ((cmd_ok && is_abort) ? abort_sel : 32'h00000000);

  // ----------------------------------------------------------------
  // Queue state
  // ----------------------------------------------------------------
  // A tag issued in the cycle of an abort stays outstanding: the issue wins
  wire [31:0] issue_bit = Q_ISSUE_I ? tag_bit(Q_ISSUE_TAG_I) : 32'h00000000;
  wire [31:0] outstand_nxt = (outstand_r & ~Q_DONE_I & ~abort_now) | issue_bit;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      outstand_r <= 32'h00000000;
      stream_r <= 32'h00000000;
      write_r <= 32'h00000000;
      isoch_r <= 32'h00000000;
      limit_hit_r <= 32'h00000000;
      wstrict_r <= 1'b0;
      rstrict_r <= 1'b0;
      abort_mask_r <= 32'h00000000;
    end
    else
    begin
      outstand_r <= outstand_nxt;
      if (Q_ISSUE_I)
      begin
        stream_r[Q_ISSUE_TAG_I] <= Q_ISSUE_STREAM_I;
        write_r[Q_ISSUE_TAG_I] <= Q_ISSUE_WRITE_I;
        isoch_r[Q_ISSUE_TAG_I] <= Q_ISSUE_PRIORITY_CLASS_I == nqd_pkg::PRIORITY_CLASS_ISOCH;
      end
      limit_hit_r <= limit_hit_r | (outstand_r & LIMIT_EXPIRED_I);
      // Strict flags change only on an accepted deadline request
      if (cmd_ok && is_deadline)
      begin
        wstrict_r <= wstrict;
        rstrict_r <= rstrict;
      end
      abort_mask_r <= abort_now;
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  // Response is held one cycle; the link layer takes it as a pulse
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      resp_valid_r <= 1'b0;
      resp_r <= '0;
    end
    // An overrun wins; a command taken in the same cycle gets no answer of its own
    else if (overrun)
    begin
      resp_valid_r <= 1'b1;
      resp_r.status <= nqd_pkg::STS_READY | nqd_pkg::STS_ERR;
      resp_r.error <= nqd_pkg::ERR_ABORTED;
      resp_r.act <= 32'h00000000;
    end
    else if (cmd_take && reject)
    begin
      resp_valid_r <= 1'b1;
      resp_r.status <= nqd_pkg::STS_READY | nqd_pkg::STS_ERR;
      resp_r.error <= nqd_pkg::ERR_ABORTED;
      resp_r.act <= 32'h00000000;
    end
    else if (cmd_ok)
    begin
      resp_valid_r <= 1'b1;
      resp_r.status <= nqd_pkg::STS_READY;
      resp_r.error <= 8'h00;
      // Own tag completes even if nothing was aborted
      resp_r.act <= tag_bit(own_tag) | (is_abort ? abort_sel : 32'h00000000);
    end
    else
    begin
      resp_valid_r <= 1'b0;
    end
  end

  assign RESP_VALID_O = resp_valid_r;
  assign RESP_O = resp_r;
  assign ABORT_MASK_O = abort_mask_r;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  wire ahb_go = HSEL && HREADY && HTRANS[1];
  wire ahb_wr = ahb_go && HWRITE;
  wire ahb_rd = ahb_go && !HWRITE;
  // Only the low byte of the address is decoded, so the map repeats every 256 bytes
  wire [7:0] ra = HADDR[7:0];
  // HSIZE is not looked at: every access is taken as a whole word

  // Address hits, one per mapped word; any other offset reads as zero
  wire hit_ctrl = ra == nqd_pkg::ADDR_CTRL;
  wire hit_status = ra == nqd_pkg::ADDR_STATUS;
  wire hit_outstand = ra == nqd_pkg::ADDR_OUTSTAND;
  wire hit_stream = ra == nqd_pkg::ADDR_STREAM;
  wire hit_isoch_wr = ra == nqd_pkg::ADDR_ISOCH_WR;
  wire hit_limit_hit = ra == nqd_pkg::ADDR_LIMIT_HIT;
  wire hit_aborted = ra == nqd_pkg::ADDR_ABORTED;

  wire [31:0] status_word = {29'h0, rstrict_r, wstrict_r, resp_valid_r};
  wire [31:0] isoch_wr_word = isoch_r & write_r;

  // Read data is registered in the address phase, so it stands for the whole data phase
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_r :
    hit_status ? status_word :
    hit_outstand ? outstand_r :
    hit_stream ? stream_r :
    hit_isoch_wr ? isoch_wr_word :
    hit_limit_hit ? limit_hit_r :
    hit_aborted ? aborted_r : 32'h00000000;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end
    else
    begin
      wr_pend_r <= ahb_wr;
      if (ahb_wr)
        wr_addr_r <= ra;
      if (ahb_rd)
        hrdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Write data follows its address by one cycle, so the hit uses the latched address
  wire wr_ctrl = wr_pend_r && wr_addr_r == nqd_pkg::ADDR_CTRL;
  // Unused control bits read back as zero
  wire [31:0] ctrl_nxt = {19'h0, HWDATA[12:8], 7'h0, HWDATA[0]};
  // Aborted history is sticky; a hardware set beats a software clear
  wire aborted_clr = wr_pend_r && wr_addr_r == nqd_pkg::ADDR_ABORTED;
  wire [31:0] aborted_kept = aborted_clr ? (aborted_r & ~HWDATA) : aborted_r;
  wire [31:0] aborted_nxt = aborted_kept | abort_now;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_r <= nqd_pkg::CTRL_RST;
      aborted_r <= 32'h00000000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= ctrl_nxt;
      aborted_r <= aborted_nxt;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

endmodule

// ===== nqd_core_properties.sv
// Concurrent checks on the command and response ports of the decoder
`timescale 1ns/100ps
module nqd_core_properties
(
  // Watched ports
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  input wire nqd_pkg::nqd_cmd_t CMD_I,
  input wire logic CMD_READY_O,
  input wire logic RESP_VALID_O,
  input wire nqd_pkg::nqd_resp_t RESP_O,
  input wire logic [31:0] ABORT_MASK_O
);
  // ------------------------------------------------------------
  // Helpers and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire take = CMD_VALID_I && CMD_READY_O && CMD_I.opcode == nqd_pkg::OPCODE;
  wire [3:0] sub = CMD_I.feature[3:0];
  wire [3:0] knd = CMD_I.feature[7:4];
  wire self_tgt = CMD_I.lba[7:3] == CMD_I.count[7:3];
  wire rej = RESP_VALID_O && RESP_O.status[0];
  wire ok = RESP_VALID_O && !RESP_O.status[0];
  AST_ANSWER: assert property (take |=> RESP_VALID_O)
    else $error("No response one cycle after a command");
  AST_REJECT_CODE: assert property (rej |-> RESP_O.error == nqd_pkg::ERR_ABORTED && RESP_O.act == 32'h0)
    else $error("Rejection without aborted code");
  AST_OK_CODE: assert property (ok |-> RESP_O.error == 8'h00 && RESP_O.status == nqd_pkg::STS_READY)
    else $error("Success with error bits");
  AST_UNKNOWN_SUB: assert property (take && sub > 4'h1 |=> rej)
    else $error("Unknown subcommand accepted");
  AST_BAD_KIND: assert property (take && sub == 4'h0 && knd > 4'h3 |=> rej)
    else $error("Unsupported abort kind accepted");
  AST_SELF_ABORT: assert property (take && sub == 4'h0 && knd == 4'h3 && self_tgt |=> rej)
    else $error("Abort of own tag accepted");
  AST_SELF_DEADLINE: assert property (take && sub == 4'h1 && self_tgt |=> rej)
    else $error("Deadline request naming own tag accepted");
  AST_DL_KIND: assert property (take && sub == 4'h1 && knd[3:2] != 2'h0 |=> rej)
    else $error("Unsupported deadline parameter accepted");
  AST_OWN_ACT: assert property (take ##1 ok |-> RESP_O.act[$past(CMD_I.count[7:3])])
    else $error("Own tag missing from completion bits");
  AST_MASK_ACKED: assert property (ok |-> (ABORT_MASK_O & ~RESP_O.act) == 32'h0)
    else $error("Aborted tag missing from completion bits");
  cover property (take && sub == 4'h0 ##1 ok);
  cover property (take && sub == 4'h1 ##1 ok);
  cover property (rej);
endmodule

// ===== nqd_decode.sv
// Field decoder and validity checks for one queued non-data command
`timescale 1ns/100ps
module nqd_decode
(
  // Command in
  input wire nqd_pkg::nqd_cmd_t cmd_i,
  // Context
  input wire logic queue_en_i,
  input wire logic [4:0] max_tag_i,
  // Decoded
  output logic is_abort_o,
  output logic is_deadline_o,
  output logic [3:0] kind_o,
  output logic [4:0] own_tag_o,
  output logic [4:0] target_tag_o,
  output logic wstrict_o,
  output logic rstrict_o,
  output logic reject_o
);

  wire [3:0] sub = cmd_i.feature[nqd_pkg::SUB_LSB +: 4];
  wire tag_clash = target_tag_o == own_tag_o;
  wire tag_bad = target_tag_o > max_tag_i;
  wire kind_bad = kind_o > nqd_pkg::ABORT_SELECTED;
  // Target tag only matters for a single-command abort among aborts; deadline requests always check it
  wire tgt_used = is_abort_o && kind_o == nqd_pkg::ABORT_SELECTED;
  // Deadline kind lives in feature bits 7:6; nonzero is unsupported
  wire dl_bad = cmd_i.feature[7:6] != 2'h0;

  // Reserved bits of feature, count, lba and device are never looked at
  assign is_abort_o = sub == nqd_pkg::SUB_ABORT;
  assign is_deadline_o = sub == nqd_pkg::SUB_DEADLINE;
  assign kind_o = cmd_i.feature[nqd_pkg::KIND_LSB +: 4];
  assign own_tag_o = cmd_i.count[nqd_pkg::TAG_LSB +: 5];
  assign target_tag_o = cmd_i.lba[nqd_pkg::TAG_LSB +: 5];
  assign wstrict_o = cmd_i.feature[nqd_pkg::WSTRICT_BIT];
  assign rstrict_o = cmd_i.feature[nqd_pkg::RSTRICT_BIT];
  assign reject_o = !queue_en_i
    || (!is_abort_o && !is_deadline_o)
    || (is_abort_o && (kind_bad || (tgt_used && (tag_clash || tag_bad))))
    || (is_deadline_o && (dl_bad || tag_clash || tag_bad));

endmodule

// ===== nqd_host_model.sv
// Host-side model that offers queued non-data commands on the command port
`timescale 1ns/100ps
module nqd_host_model
(
  // Clock
  input wire logic clk_i,
  // Command port
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output nqd_pkg::nqd_cmd_t cmd_o
);
  // ------------------------------------------------------------
  // Command issue
  // ------------------------------------------------------------
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  task automatic send(input logic [3:0] s, k, input logic [4:0] t, g, input logic [7:0] rsv);
    nqd_pkg::nqd_cmd_t c;
    logic r;
    c.feature = {rsv, k, s};
    c.count = {2'h0, 6'h00, t, 3'h0};
    c.lba = {{5{rsv}}, g, 3'h0};
    c.device = 8'h40;
    c.opcode = nqd_pkg::OPCODE;
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= c;
    forever
    begin
      @(negedge clk_i) r = cmd_ready_i;
      @(posedge clk_i);
      if (r) break;
    end
    cmd_valid_o <= 1'b0;
    // Released fields must not keep looking valid
    cmd_o <= ~c;
  endtask
endmodule

// ===== nqd_pkg.sv
// Package of constants and carrier types for the queued non-data command decoder
package nqd_pkg;

  // ----------------------------------------------------------------
  // Command fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OPCODE = 8'h63;
  localparam logic [3:0] SUB_ABORT = 4'h0;
  localparam logic [3:0] SUB_DEADLINE = 4'h1;
  localparam logic [3:0] ABORT_ALL = 4'h0;
  localparam logic [3:0] ABORT_STREAM = 4'h1;
  localparam logic [3:0] ABORT_NONSTREAM = 4'h2;
  localparam logic [3:0] ABORT_SELECTED = 4'h3;
  localparam int SUB_LSB = 0;
  localparam int KIND_LSB = 4;
  localparam int WSTRICT_BIT = 4;
  localparam int RSTRICT_BIT = 5;
  localparam int TAG_LSB = 3;
  localparam int PRIORITY_CLASS_LSB = 14;
  localparam int DEV_ONE_BIT = 6;
  localparam int DEV_ZERO_BIT = 4;
  localparam logic [1:0] PRIORITY_CLASS_ISOCH = 2'h1;
  localparam int NTAGS = 32;
  localparam logic [7:0] ERR_ABORTED = 8'h04;
  localparam logic [7:0] STS_ERR = 8'h01;
  localparam logic [7:0] STS_READY = 8'h40;

  // ----------------------------------------------------------------
  // Register map (AHB-Lite)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OUTSTAND = 8'h08;
  localparam logic [7:0] ADDR_STREAM = 8'h0c;
  localparam logic [7:0] ADDR_ISOCH_WR = 8'h10;
  localparam logic [7:0] ADDR_LIMIT_HIT = 8'h14;
  localparam logic [7:0] ADDR_ABORTED = 8'h18;
  localparam int CTRL_QEN_BIT = 0;
  localparam logic [4:0] MAXTAG_RST = 5'h1f;
  localparam logic [31:0] CTRL_RST = 32'h00001f01;

  typedef struct packed {
    logic [15:0] feature;
    logic [15:0] count;
    logic [47:0] lba;
    logic [7:0] device;
    logic [7:0] opcode;
  } nqd_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [31:0] act;
  } nqd_resp_t;

endpackage

// ===== tb_ncq_nondata_cmd_decoder.sv
// Testbench: command, queue and register scenarios for the decoder
`timescale 1ns/100ps
module tb_ncq_nondata_cmd_decoder;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic cmd_valid, cmd_ready, resp_valid, hready, qi_v = 1'b0, qs = 1'b0, qw = 1'b0;
  logic hwrite = 1'b0;
  logic [4:0] qt = 5'h00;
  logic [1:0] qp = 2'h0, htrans = 2'h0;
  logic [31:0] exp_m = 32'h0, qd = 32'h0, haddr = 32'h0, hwdata = 32'h0, hrdata, amask, hr;
  nqd_pkg::nqd_cmd_t cmd;
  nqd_pkg::nqd_resp_t resp;
  int miscompares = 0;
  int num_checks = 0;
  always #2.5 CLK_I = ~CLK_I;
  nqd_host_model nqd_host_model_inst (.clk_i(CLK_I), .cmd_ready_i(cmd_ready),
    .cmd_valid_o(cmd_valid), .cmd_o(cmd));
  nqd_core nqd_core_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CMD_VALID_I(cmd_valid),
    .CMD_I(cmd), .CMD_READY_O(cmd_ready), .Q_ISSUE_I(qi_v), .Q_ISSUE_TAG_I(qt),
    .Q_ISSUE_STREAM_I(qs), .Q_ISSUE_WRITE_I(qw), .Q_ISSUE_PRIORITY_CLASS_I(qp), .Q_DONE_I(qd),
    .LIMIT_EXPIRED_I(exp_m), .RESP_VALID_O(resp_valid), .RESP_O(resp), .ABORT_MASK_O(amask),
    .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP());
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrdy();
    logic r;
    forever
    begin
      @(negedge CLK_I) r = hready;
      hr = hrdata;
      @(posedge CLK_I);
      if (r) break;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wrdy();
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("register", e, hr);
  endtask
  task automatic rsp(input logic err, input logic [31:0] act, input logic [31:0] mask);
    int n;
    n = 0;
    // The answer is launched by an edge; look at it mid-cycle, never in that edge's step
    @(negedge CLK_I);
    while (resp_valid !== 1'b1 && n < 4)
    begin
      @(negedge CLK_I);
      n++;
    end
    chk("resp_valid", 32'h1, {31'h0, resp_valid});
    chk("status", {24'h0, nqd_pkg::STS_READY | (err ? nqd_pkg::STS_ERR : 8'h00)}, {24'h0, resp.status});
    chk("error", err ? {24'h0, nqd_pkg::ERR_ABORTED} : 32'h0, {24'h0, resp.error});
    chk("act", act, resp.act);
    chk("abort_mask", mask, amask);
    @(posedge CLK_I);
  endtask
  task automatic cmd_do(input logic [3:0] s, k, input logic [4:0] t, g, input logic err,
                        input logic [31:0] act);
    // Reserved bits of feature and lba are kept nonzero so they must be ignored
    nqd_host_model_inst.send(s, k, t, g, 8'ha5);
    // Aborted tags are the completion bits without the command's own tag
    rsp(err, act, err ? 32'h0 : act & ~(32'h00000001 << t));
  endtask
  task automatic qi(input logic [4:0] t, input logic s, w, input logic [1:0] p);
    @(posedge CLK_I);
    qi_v <= 1'b1;
    qt <= t;
    qs <= s;
    qw <= w;
    qp <= p;
    @(posedge CLK_I);
    qi_v <= 1'b0;
  endtask
  task automatic expire(input logic [31:0] m);
    @(posedge CLK_I);
    exp_m <= m;
    @(posedge CLK_I);
    exp_m <= 32'h0;
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    rd(nqd_pkg::ADDR_CTRL, nqd_pkg::CTRL_RST);
    rd(8'h20, 32'h0);
    qi(5'd2, 1'b1, 1'b0, 2'h0);
    qi(5'd3, 1'b0, 1'b0, 2'h0);
    qi(5'd5, 1'b0, 1'b1, nqd_pkg::PRIORITY_CLASS_ISOCH);
    rd(nqd_pkg::ADDR_OUTSTAND, 32'h2c);
    rd(nqd_pkg::ADDR_STREAM, 32'h4);
    rd(nqd_pkg::ADDR_ISOCH_WR, 32'h20);
    cmd_do(4'h0, 4'h1, 5'd9, 5'd0, 1'b0, 32'h204);
    cmd_do(4'h0, 4'h3, 5'd10, 5'd3, 1'b0, 32'h408);
    cmd_do(4'h0, 4'h3, 5'd11, 5'd3, 1'b0, 32'h800);
    rd(nqd_pkg::ADDR_OUTSTAND, 32'h20);
    cmd_do(4'h0, 4'h4, 5'd12, 5'd0, 1'b1, 32'h0);
    cmd_do(4'h0, 4'h3, 5'd12, 5'd12, 1'b1, 32'h0);
    cmd_do(4'h2, 4'h0, 5'd12, 5'd0, 1'b1, 32'h0);
    cmd_do(4'h1, 4'h4, 5'd12, 5'd0, 1'b1, 32'h0);
    cmd_do(4'h1, 4'h1, 5'd12, 5'd12, 1'b1, 32'h0);
    cmd_do(4'h1, 4'h1, 5'd13, 5'd0, 1'b0, 32'h2000);
    rd(nqd_pkg::ADDR_STATUS, 32'h2);
    qi(5'd6, 1'b0, 1'b1, 2'h0);
    expire(32'h40);
    repeat (3) @(negedge CLK_I) chk("resp_valid", 32'h0, {31'h0, resp_valid});
    expire(32'h20);
    rsp(1'b1, 32'h0, 32'h60);
    rd(nqd_pkg::ADDR_OUTSTAND, 32'h0);
    rd(nqd_pkg::ADDR_LIMIT_HIT, 32'h60);
    rd(nqd_pkg::ADDR_ABORTED, 32'h6c);
    ahb(1'b1, nqd_pkg::ADDR_ABORTED, 32'h6c);
    rd(nqd_pkg::ADDR_ABORTED, 32'h0);
    cmd_do(4'h1, 4'h2, 5'd16, 5'd0, 1'b0, 32'h10000);
    qi(5'd8, 1'b0, 1'b0, nqd_pkg::PRIORITY_CLASS_ISOCH);
    expire(32'h100);
    rsp(1'b1, 32'h0, 32'h100);
    ahb(1'b1, nqd_pkg::ADDR_CTRL, 32'h1f00);
    cmd_do(4'h0, 4'h0, 5'd14, 5'd0, 1'b1, 32'h0);
    ahb(1'b1, nqd_pkg::ADDR_CTRL, nqd_pkg::CTRL_RST);
    qi(5'd7, 1'b0, 1'b0, 2'h0);
    qi(5'd20, 1'b1, 1'b0, 2'h0);
    qi(5'd4, 1'b0, 1'b0, 2'h0);
    // Tag 4 completes on the data path, so the later aborts must not name it
    @(posedge CLK_I);
    qd <= 32'h00000010;
    @(posedge CLK_I);
    qd <= 32'h0;
    rd(nqd_pkg::ADDR_OUTSTAND, 32'h100080);
    cmd_do(4'h0, 4'h2, 5'd22, 5'd0, 1'b0, 32'h400080);
    cmd_do(4'h0, 4'h0, 5'd15, 5'd0, 1'b0, 32'h108000);
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge CLK_I);
    miscompares++;
    summarize();
  end
endmodule
bind nqd_core nqd_core_properties nqd_core_properties_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I), .CMD_READY_O(CMD_READY_O),
  .RESP_VALID_O(RESP_VALID_O), .RESP_O(RESP_O), .ABORT_MASK_O(ABORT_MASK_O));
